// ### rtl/tmr_cfg.svh
// Register indices, field positions, reset values and counts of the timer.
// Assumes an 8-bit internal I/O register port with one index per register.
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

`define TMR_ADDR_W        4
`define TMR_IDX_CTRL_A    4'h0
`define TMR_IDX_CTRL_B    4'h1
`define TMR_IDX_FORCE     4'h2
`define TMR_IDX_IRQ_EN    4'h3
`define TMR_IDX_IRQ_FLAG  4'h4
`define TMR_IDX_CNT_L     4'h5
`define TMR_IDX_CNT_H     4'h6
`define TMR_IDX_CAP_L     4'h7
`define TMR_IDX_CAP_H     4'h8
`define TMR_IDX_MA_L      4'h9
`define TMR_IDX_MA_H      4'hA
`define TMR_IDX_MB_L      4'hB
`define TMR_IDX_MB_H      4'hC
`define TMR_IDX_MC_L      4'hD
`define TMR_IDX_MC_H      4'hE

`define TMR_REG_RESET     8'h00
`define TMR_FLAG_MASK     8'h2F
`define TMR_CTRL_B_MASK   8'h5F
`define TMR_BIT_CAP       5
`define TMR_BIT_OVF       0
`define TMR_BIT_EDGE      6
`define TMR_FORCE_LSB     5

`define TMR_TOP_8BIT      16'h00FF
`define TMR_TOP_9BIT      16'h01FF
`define TMR_TOP_10BIT     16'h03FF
`define TMR_TOP_MAX       16'hFFFF
`define TMR_PRESC_W       10
`endif

// ### rtl/tmr_pkg.sv
// Types shared by the timer modules.
// Assumes the constants of tmr_cfg.svh.
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_OVF_AT_MAX    = 2'b00,
    TMR_OVF_AT_TOP    = 2'b01,
    TMR_OVF_AT_BOTTOM = 2'b10
  } tmr_ovf_pt_e;

  typedef logic [15:0] tmr_word_t;
endpackage

// ### rtl/tmr_clksel.sv
// Clock source selection and prescaler of one timer.
// Assumes the count pin is synchronous to clk.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_clksel #(
  parameter int PRESC_W = `TMR_PRESC_W
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Control
  input  wire logic [2:0] sel,
  input  wire logic       ext_pin,
  // Timer clock enable
  output logic            tick
);
  logic [PRESC_W-1:0] presc;
  logic               ext_q;

  always_ff @(posedge clk)
  begin
    if (srst)
      presc <= '0;
    else
      presc <= presc + PRESC_W'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      ext_q <= 1'b0;
    else
      ext_q <= ext_pin;
  end

  // Pin direction is not looked at: a driven output still counts
  always_comb
  begin
    case (sel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = &presc[2:0];
      3'h3: tick = &presc[5:0];
      3'h4: tick = &presc[7:0];
      3'h5: tick = &presc[9:0];
      3'h6: tick = ext_q & ~ext_pin;
      3'h7: tick = ~ext_q & ext_pin;
      default: tick = 1'b0;
    endcase
  end

  AST_DIV1_TICK: assert property (@(posedge clk) disable iff (srst)
    (sel == 3'h1) |-> tick)
    else $error("divide by one did not tick");
  AST_EXT_RISE: assert property (@(posedge clk) disable iff (srst)
    (sel == 3'h7 && !ext_q && ext_pin) |-> tick)
    else $error("rising edge on count pin missed");
  AST_EXT_FALL_ONLY: assert property (@(posedge clk) disable iff (srst)
    (sel == 3'h6 && tick) |-> ($past(ext_pin) && !ext_pin))
    else $error("falling mode ticked without falling edge");
endmodule

// ### rtl/tmr_cmp.sv
// One compare channel: equality, suppressed match and forced strobe.
// Assumes tick, counter and block come from the timer core.
`timescale 1ns/1ps
module tmr_cmp (
  // Counter side
  input  wire logic [15:0] cnt,
  input  wire logic [15:0] match_value,
  input  wire logic        tick,
  input  wire logic        blocked,
  // Forced strobe side
  input  wire logic        force_wr,
  input  wire logic        pwm_mode,
  // Results
  output logic             hit,
  output logic             forced
);
  assign hit = tick && !blocked && (cnt == match_value);
  assign forced = force_wr && !pwm_mode;
endmodule

// ### rtl/tmr_top.sv
// Functional notes
// - Clock select zero stops counter; codes 1-5 divide I/O clock by 1..1024.
// - Codes six and seven count falling or rising edges of the count pin.
// - Pin edges count even when the pin is driven as an output.
// - Force strobe outside PWM gives an immediate match to the waveform unit.
// - A forced match sets no flag, raises no request, never clears the counter.
// - Force strobe bits always read back as zero.
// - Counter is read and written as byte pair through the shared latch.
// - Counter write suppresses all compare matches on the next timer clock.
// - Three compare values are compared with the counter at all times.
// - Compare value writes update both bytes together via the latch.
// - Capture event loads the counter into the captured value.
// - Captured value reads return both bytes together via the latch.
// - Request needs its enable, the global enable and its pending flag.
// - Capture flag sets on capture, or at top when captured value is top.
// - Match flag sets on the timer clock after counter equals compare value.
// - Overflow flag sets at overflow in normal and clear modes, else per mode.
// - Flags clear on vector acknowledge or by writing one to them.
// - Waveform mode selects top value and the overflow flag point.
// - Edge select picks capture edge; capture is off while it is top.
//
// One 16-bit timer core with its control, flag and 16-bit registers.
// Assumes an 8-bit I/O register port, inputs synchronous to CLK.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_top #(
  parameter int  ADDR_W   = `TMR_ADDR_W,
  parameter bit  HAS_ACMP = 1'b1
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              SRST,
  // I/O register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WE,
  input  wire logic              RE,
  output logic      [7:0]        RDATA,
  // Interrupt side
  input  wire logic              GIE,
  input  wire logic [4:0]        IRQ_ACK,
  output logic      [4:0]        IRQ_REQ,
  // Pins and events
  input  wire logic              EXT_COUNT_PIN,
  input  wire logic              CAPTURE_EVENT_PIN,
  input  wire logic              ACMP_OUT,
  input  wire logic              ACMP_CAPTURE_SEL,
  // Waveform unit side
  output logic      [2:0]        MATCH_EVT,
  output logic      [2:0]        FORCE_EVT,
  output logic      [5:0]        COMPARE_ACTION,
  output logic      [3:0]        WAVEFORM_SEL,
  output logic      [15:0]       COUNT_VALUE
);
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [7:0]  irq_en;
  logic [7:0]  flags;
  logic [7:0]  temp;
  logic [15:0] cnt;
  logic [15:0] cap;
  logic [15:0] mv [3];
  logic        dir_down;
  logic        blk;
  logic        cap_q;
  logic        tick;
  logic [2:0]  hit;
  logic [2:0]  forced;
  logic [7:0]  next_rdata;
  logic [3:0]  wsel;
  tmr_pkg::tmr_word_t top;
  tmr_pkg::tmr_ovf_pt_e ovf_pt;

  function automatic logic wr_at(input logic [ADDR_W-1:0] idx);
    wr_at = WE && (ADDR == idx);
  endfunction

  function automatic logic rd_at(input logic [ADDR_W-1:0] idx);
    rd_at = RE && (ADDR == idx);
  endfunction

  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'd8) || (m == 4'd10) || (m == 4'd12) ||
                 (m == 4'd14);
  endfunction

  function automatic logic phase_mode(input logic [3:0] m);
    phase_mode = ((m >= 4'd1) && (m <= 4'd3)) ||
                 ((m >= 4'd8) && (m <= 4'd11));
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = !((m == 4'd0) || (m == 4'd4) || (m == 4'd12) ||
               (m == 4'd13));
  endfunction

  assign wsel = {ctrl_b[4:3], ctrl_a[1:0]};

  always_comb
  begin
    case (wsel)
      4'd1, 4'd5:
        top = `TMR_TOP_8BIT;
      4'd2, 4'd6:
        top = `TMR_TOP_9BIT;
      4'd3, 4'd7:
        top = `TMR_TOP_10BIT;
      4'd4, 4'd9, 4'd11, 4'd15:
        top = mv[0];
      4'd8, 4'd10, 4'd12, 4'd14:
        top = cap;
      default:
        top = `TMR_TOP_MAX;
    endcase
    if (phase_mode(wsel))
      ovf_pt = tmr_pkg::TMR_OVF_AT_BOTTOM;
    else if (is_pwm(wsel))
      ovf_pt = tmr_pkg::TMR_OVF_AT_TOP;
    else
      ovf_pt = tmr_pkg::TMR_OVF_AT_MAX;
  end

  tmr_clksel #(
    .PRESC_W (`TMR_PRESC_W)
  ) u_clksel (
    .clk     (CLK),
    .srst    (SRST),
    .sel     (ctrl_b[2:0]),
    .ext_pin (EXT_COUNT_PIN),
    .tick    (tick)
  );

  for (genvar i = 0; i < 3; i++)
  begin : g_cmp
    tmr_cmp u_cmp (
      .cnt         (cnt),
      .match_value (mv[i]),
      .tick        (tick),
      .blocked     (blk),
      .force_wr    (wr_at(`TMR_IDX_FORCE) && WDATA[7-i]),
      .pwm_mode    (is_pwm(wsel)),
      .hit         (hit[i]),
      .forced      (forced[i])
    );
  end

  // Control registers; reserved bits are never stored
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ctrl_a <= `TMR_REG_RESET;
      ctrl_b <= `TMR_REG_RESET;
      irq_en <= `TMR_REG_RESET;
    end
    else
    begin
      if (wr_at(`TMR_IDX_CTRL_A))
        ctrl_a <= WDATA;
      if (wr_at(`TMR_IDX_CTRL_B))
        ctrl_b <= WDATA & `TMR_CTRL_B_MASK;
      if (wr_at(`TMR_IDX_IRQ_EN))
        irq_en <= WDATA & `TMR_FLAG_MASK;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      temp <= `TMR_REG_RESET;
    else if (wr_at(`TMR_IDX_CNT_H) || wr_at(`TMR_IDX_CAP_H) ||
             wr_at(`TMR_IDX_MA_H) || wr_at(`TMR_IDX_MB_H) ||
             wr_at(`TMR_IDX_MC_H))
      temp <= WDATA;
    else if (rd_at(`TMR_IDX_CNT_L))
      temp <= cnt[15:8];
    else if (rd_at(`TMR_IDX_CAP_L))
      temp <= cap[15:8];
  end

  // Written-counter block lasts until the next timer clock
  always_ff @(posedge CLK)
  begin
    if (SRST)
      blk <= 1'b0;
    else if (wr_at(`TMR_IDX_CNT_L))
      blk <= 1'b1;
    else if (tick)
      blk <= 1'b0;
  end

  // CPU write has priority over counting
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      cnt      <= 16'h0000;
      dir_down <= 1'b0;
    end
    else if (wr_at(`TMR_IDX_CNT_L))
      cnt <= {temp, WDATA};
    else if (tick)
    begin
      if (phase_mode(wsel))
      begin
        if (!dir_down && cnt >= top)
        begin
          dir_down <= 1'b1;
          cnt      <= cnt - 16'h0001;
        end
        else if (dir_down && cnt == 16'h0000)
        begin
          dir_down <= 1'b0;
          cnt      <= 16'h0001;
        end
        else if (dir_down)
          cnt <= cnt - 16'h0001;
        else
          cnt <= cnt + 16'h0001;
      end
      // Match-cleared modes wrap at top; forced strobes never get here
      else if (cnt == top)
      begin
        dir_down <= 1'b0;
        cnt      <= 16'h0000;
      end
      else
      begin
        dir_down <= 1'b0;
        cnt      <= cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mv[0] <= 16'h0000;
      mv[1] <= 16'h0000;
      mv[2] <= 16'h0000;
    end
    else
    begin
      if (wr_at(`TMR_IDX_MA_L))
        mv[0] <= {temp, WDATA};
      if (wr_at(`TMR_IDX_MB_L))
        mv[1] <= {temp, WDATA};
      if (wr_at(`TMR_IDX_MC_L))
        mv[2] <= {temp, WDATA};
    end
  end

  // Capture source edge detect; the pins are already synchronous
  logic cap_src;
  logic cap_evt;
  assign cap_src = (HAS_ACMP && ACMP_CAPTURE_SEL) ? ACMP_OUT
                                                  : CAPTURE_EVENT_PIN;
  assign cap_evt = !cap_is_top(wsel) &&
                   (ctrl_b[`TMR_BIT_EDGE] ? (cap_src && !cap_q)
                                          : (!cap_src && cap_q));

  always_ff @(posedge CLK)
  begin
    if (SRST)
      cap_q <= 1'b0;
    else
      cap_q <= cap_src;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      cap <= 16'h0000;
    else if (cap_evt)
      cap <= cnt;
    else if (wr_at(`TMR_IDX_CAP_L))
      cap <= {temp, WDATA};
  end

  // Flag set sources, in flag register bit order
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       ovf_hit;
  always_comb
  begin
    case (ovf_pt)
      tmr_pkg::TMR_OVF_AT_TOP:
        ovf_hit = tick && (cnt == top);
      tmr_pkg::TMR_OVF_AT_BOTTOM:
        ovf_hit = tick && dir_down && (cnt == 16'h0000);
      default:
        ovf_hit = tick && (cnt == `TMR_TOP_MAX);
    endcase
    set_v = 8'h00;
    set_v[`TMR_BIT_CAP] = cap_evt ||
                          (cap_is_top(wsel) && tick && (cnt == top));
    set_v[3:1] = hit;
    set_v[`TMR_BIT_OVF] = ovf_hit;
    clr_v = {2'b00, IRQ_ACK[4], 1'b0, IRQ_ACK[3:0]};
    if (wr_at(`TMR_IDX_IRQ_FLAG))
      clr_v = clr_v | WDATA;
  end

  // clear by ack or one, set wins
  always_ff @(posedge CLK)
  begin
    if (SRST)
      flags <= `TMR_REG_RESET;
    else
      flags <= ((flags & ~clr_v) | set_v) & `TMR_FLAG_MASK;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      IRQ_REQ <= 5'h00;
    else if (GIE)
      IRQ_REQ <= {irq_en[5] & flags[5], irq_en[3:0] & flags[3:0]};
    else
      IRQ_REQ <= 5'h00;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      MATCH_EVT      <= 3'h0;
      FORCE_EVT      <= 3'h0;
      COMPARE_ACTION <= 6'h00;
      WAVEFORM_SEL   <= 4'h0;
      COUNT_VALUE    <= 16'h0000;
    end
    else
    begin
      MATCH_EVT      <= hit;
      FORCE_EVT      <= forced;
      COMPARE_ACTION <= ctrl_a[7:2];
      WAVEFORM_SEL   <= wsel;
      COUNT_VALUE    <= cnt;
    end
  end

  always_comb
  begin
    case (ADDR)
      `TMR_IDX_CTRL_A:   next_rdata = ctrl_a;
      `TMR_IDX_CTRL_B:   next_rdata = ctrl_b;
      `TMR_IDX_FORCE:    next_rdata = 8'h00;
      `TMR_IDX_IRQ_EN:   next_rdata = irq_en;
      `TMR_IDX_IRQ_FLAG: next_rdata = flags;
      `TMR_IDX_CNT_L:    next_rdata = cnt[7:0];
      `TMR_IDX_CAP_L:    next_rdata = cap[7:0];
      `TMR_IDX_CNT_H,
      `TMR_IDX_CAP_H:    next_rdata = temp;
      `TMR_IDX_MA_L:     next_rdata = mv[0][7:0];
      `TMR_IDX_MA_H:     next_rdata = mv[0][15:8];
      `TMR_IDX_MB_L:     next_rdata = mv[1][7:0];
      `TMR_IDX_MB_H:     next_rdata = mv[1][15:8];
      `TMR_IDX_MC_L:     next_rdata = mv[2][7:0];
      `TMR_IDX_MC_H:     next_rdata = mv[2][15:8];
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
      RDATA <= 8'h00;
    else if (RE)
      RDATA <= next_rdata;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  AST_STOPPED: assert property (
    (ctrl_b[2:0] == 3'h0 && !WE) |=> (cnt == $past(cnt)))
    else $error("counter moved while stopped");
  AST_FORCE_RD0: assert property (
    (RE && ADDR == `TMR_IDX_FORCE) |=> (RDATA == 8'h00))
    else $error("force strobes read nonzero");
  AST_FLAG_NEEDS_MATCH: assert property (
    (!flags[1] && !WE) ##1 flags[1] |-> MATCH_EVT[0])
    else $error("match flag rose without a true match");
  AST_WR_BLOCK: assert property (
    wr_at(`TMR_IDX_CNT_L) ##1 (!wr_at(`TMR_IDX_CNT_L) && tick)
      |-> (hit == 3'h0))
    else $error("match not suppressed after counter write");
  AST_MATCH_FLAG: assert property (
    (tick && !blk && cnt == mv[0]) |=> (flags[1] && MATCH_EVT[0]))
    else $error("match flag not set after equality");
  AST_IRQ_REQ: assert property (
    (GIE && irq_en[0] && flags[0]) |=> IRQ_REQ[0])
    else $error("overflow request missing");
  AST_W1C: assert property (
    (wr_at(`TMR_IDX_IRQ_FLAG) && WDATA[0] && !ovf_hit) |=> !flags[0])
    else $error("overflow flag not cleared by one");
  AST_CMP16: assert property (
    wr_at(`TMR_IDX_MA_L) |=> (mv[0] == {$past(temp), $past(WDATA)}))
    else $error("compare A not written as a pair");
  AST_CAPTURE: assert property (
    cap_evt |=> (cap == $past(cnt)) && flags[`TMR_BIT_CAP])
    else $error("capture did not load counter and flag");
  AST_NORMAL_OVF: assert property (
    (wsel == 4'd0 && tick && cnt == `TMR_TOP_MAX && !WE)
      |=> (flags[0] && cnt == 16'h0000))
    else $error("normal mode overflow wrong");

  COV_MATCH_IRQ:  cover property (MATCH_EVT[0] ##[1:3] IRQ_REQ[1]);
  COV_FORCE:      cover property (FORCE_EVT[1]);
  COV_CAPTURE:    cover property (cap_evt ##1 flags[`TMR_BIT_CAP]);
  COV_PHASE_OVF:  cover property (phase_mode(wsel) && ovf_hit);
endmodule

// ### dv/tmr_cpu_model.sv
// Processor-side model of the timer's I/O register port.
// Assumes the design takes strobes on the rising edge of clk.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tmr_cpu_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            we,
  output logic            re,
  input  wire logic [7:0] rdata
);
  initial
  begin
    addr  = 4'h0;
    wdata = 8'h00;
    we    = 1'b0;
    re    = 1'b0;
  end

  // Strobe spans one rising edge; a gap cycle keeps each call distinct
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    we    = 1'b1;
    @(negedge clk);
    we    = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    re   = 1'b1;
    @(negedge clk);
    re   = 1'b0;
    @(negedge clk);
    d    = rdata;
  endtask

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
endmodule

// ### dv/sixteen_bit_timer_control_regs_bench.sv
// Self-checking bench for one timer instance driven through its byte port.
// Assumes tmr_top with default parameters and the register indices of
// tmr_cfg.svh; all stimulus changes on the falling clock edge.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module sixteen_bit_timer_control_regs_bench;
  logic        CLK;
  logic        SRST;
  logic [3:0]  ADDR;
  logic [7:0]  WDATA;
  logic        WE;
  logic        RE;
  logic [7:0]  RDATA;
  logic        GIE;
  logic [4:0]  IRQ_ACK;
  logic [4:0]  IRQ_REQ;
  logic        EXT_COUNT_PIN;
  logic        CAPTURE_EVENT_PIN;
  logic        ACMP_OUT;
  logic        ACMP_CAPTURE_SEL;
  logic [2:0]  MATCH_EVT;
  logic [2:0]  FORCE_EVT;
  logic [5:0]  COMPARE_ACTION;
  logic [3:0]  WAVEFORM_SEL;
  logic [15:0] COUNT_VALUE;
  int          n_fail;
  int          tests_run;
  logic [7:0]  b;
  logic [15:0] w;
  logic [2:0]  seen_force;
  logic [2:0]  seen_match;
  int          divs [5] = '{1, 8, 64, 256, 1024};

  always #2.5 CLK = ~CLK;

  // Event pulses last one cycle, so they are gathered rather than sampled
  always @(posedge CLK)
  begin
    seen_force <= seen_force | FORCE_EVT;
    seen_match <= seen_match | MATCH_EVT;
  end

  tmr_top dut (
    .CLK               (CLK),
    .SRST              (SRST),
    .ADDR              (ADDR),
    .WDATA             (WDATA),
    .WE                (WE),
    .RE                (RE),
    .RDATA             (RDATA),
    .GIE               (GIE),
    .IRQ_ACK           (IRQ_ACK),
    .IRQ_REQ           (IRQ_REQ),
    .EXT_COUNT_PIN     (EXT_COUNT_PIN),
    .CAPTURE_EVENT_PIN (CAPTURE_EVENT_PIN),
    .ACMP_OUT          (ACMP_OUT),
    .ACMP_CAPTURE_SEL  (ACMP_CAPTURE_SEL),
    .MATCH_EVT         (MATCH_EVT),
    .FORCE_EVT         (FORCE_EVT),
    .COMPARE_ACTION    (COMPARE_ACTION),
    .WAVEFORM_SEL      (WAVEFORM_SEL),
    .COUNT_VALUE       (COUNT_VALUE)
  );

  tmr_cpu_model cpu (
    .clk   (CLK),
    .addr  (ADDR),
    .wdata (WDATA),
    .we    (WE),
    .re    (RE),
    .rdata (RDATA)
  );

  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic run_for(input int n, input logic [7:0] ctrl_b);
    cpu.wr(`TMR_IDX_CTRL_B, ctrl_b);
    cycles(n);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h00);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard: the full sequence needs about 10600 cycles
  initial
  begin
    repeat (40000) @(posedge CLK);
    n_fail++;
    $display("unexpected run length: expected finish seen hang");
    conclude();
  end

  initial
  begin
    CLK = 1'b0;
    SRST = 1'b1;
    GIE = 1'b1;
    IRQ_ACK = 5'h00;
    EXT_COUNT_PIN = 1'b0;
    CAPTURE_EVENT_PIN = 1'b1;
    ACMP_OUT = 1'b0;
    ACMP_CAPTURE_SEL = 1'b0;
    n_fail = 0;
    tests_run = 0;
    seen_force = 3'h0;
    seen_match = 3'h0;
    repeat (5) @(negedge CLK);
    SRST = 1'b0;

    for (int i = 0; i < 16; i++)
    begin
      cpu.rd(i[3:0], b);
      check("reset value", 16'(b), 16'h0000);
    end
    $display("test reset done");

    cpu.wr(`TMR_IDX_IRQ_EN, 8'hFF);
    cpu.rd(`TMR_IDX_IRQ_EN, b);
    check("irq enable", 16'(b), 16'h002F);
    cpu.wr16(`TMR_IDX_MA_L, 16'hBEEF);
    cpu.rd16(`TMR_IDX_MA_L, w);
    check("compare word", w, 16'hBEEF);
    cpu.wr16(`TMR_IDX_CNT_L, 16'h1234);
    cpu.rd16(`TMR_IDX_CNT_L, w);
    check("count word", w, 16'h1234);
    check("count port", COUNT_VALUE, 16'h1234);
    cpu.rd(`TMR_IDX_CNT_L, b);
    cpu.wr(`TMR_IDX_MB_L, 8'h33);
    cpu.rd(`TMR_IDX_MB_H, b);
    check("shared latch", 16'(b), 16'h0012);
    $display("test registers done");

    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'hFF);
    seen_force = 3'h0;
    cpu.wr(`TMR_IDX_FORCE, 8'hFF);
    cycles(2);
    check("force events", 16'(seen_force), 16'h0007);
    cpu.rd(`TMR_IDX_FORCE, b);
    check("force readback", 16'(b), 16'h0000);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("flags after force", 16'(b), 16'h0000);
    check("request after force", 16'(IRQ_REQ), 16'h0000);
    check("count after force", COUNT_VALUE, 16'h1234);
    cpu.wr(`TMR_IDX_CTRL_A, 8'hA5);
    cycles(2);
    check("mode port", 16'(WAVEFORM_SEL), 16'h0001);
    check("action port", 16'(COMPARE_ACTION), 16'h0029);
    seen_force = 3'h0;
    cpu.wr(`TMR_IDX_FORCE, 8'hE0);
    cycles(2);
    check("force in pwm", 16'(seen_force), 16'h0000);
    cpu.wr(`TMR_IDX_CTRL_A, 8'h00);
    $display("test force done");

    for (int k = 0; k < 5; k++)
    begin
      cpu.wr16(`TMR_IDX_CNT_L, 16'h0000);
      run_for(2048, 8'(k + 1));
      cpu.rd16(`TMR_IDX_CNT_L, w);
      check("prescale", 16'(w >= 2048 / divs[k] - 1 &&
            w <= 2054 / divs[k] + 1), 16'h0001);
    end
    cycles(20);
    check("stopped count", COUNT_VALUE, w);
    // Five toggles give two edges of the chosen kind and three of the other
    for (int k = 6; k < 8; k++)
    begin
      cpu.wr16(`TMR_IDX_CNT_L, 16'h0000);
      cpu.wr(`TMR_IDX_CTRL_B, 8'(k));
      repeat (5)
      begin
        cycles(2);
        EXT_COUNT_PIN = ~EXT_COUNT_PIN;
      end
      cycles(3);
      cpu.wr(`TMR_IDX_CTRL_B, 8'h00);
      cpu.rd16(`TMR_IDX_CNT_L, w);
      check("pin edges", w, 16'h0002);
    end
    $display("test clock select done");

    cpu.wr16(`TMR_IDX_MA_L, 16'h0005);
    cpu.wr16(`TMR_IDX_CNT_L, 16'h0003);
    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'hFF);
    seen_match = 3'h0;
    run_for(6, 8'h01);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("match flag", 16'(b), 16'h0002);
    check("match event", 16'(seen_match), 16'h0001);
    check("match request", 16'(IRQ_REQ), 16'h0002);
    GIE = 1'b0;
    cycles(2);
    check("masked request", 16'(IRQ_REQ), 16'h0000);
    GIE = 1'b1;
    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'h01);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("flag kept", 16'(b), 16'h0002);
    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'h02);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("flag cleared", 16'(b), 16'h0000);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h01);
    cpu.wr16(`TMR_IDX_CNT_L, 16'h0005);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h00);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("blocked match", 16'(b), 16'h0000);
    $display("test compare done");

    cpu.wr16(`TMR_IDX_CNT_L, 16'hFFFE);
    run_for(2, 8'h01);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("overflow flag", 16'(b & 8'h01), 16'h0001);
    check("overflow request", 16'(IRQ_REQ[0]), 16'h0001);
    cycles(1);
    IRQ_ACK = 5'h1F;
    cycles(1);
    IRQ_ACK = 5'h00;
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("acked flags", 16'(b), 16'h0000);
    check("acked request", 16'(IRQ_REQ), 16'h0000);
    $display("test overflow done");

    cpu.wr16(`TMR_IDX_CNT_L, 16'h3C5A);
    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'hFF);
    CAPTURE_EVENT_PIN = 1'b0;
    cycles(3);
    cpu.rd16(`TMR_IDX_CAP_L, w);
    check("capture falling", w, 16'h3C5A);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("capture flag", 16'(b), 16'h0020);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h40);
    cpu.wr16(`TMR_IDX_CNT_L, 16'h0102);
    CAPTURE_EVENT_PIN = 1'b1;
    cycles(3);
    cpu.rd16(`TMR_IDX_CAP_L, w);
    check("capture rising", w, 16'h0102);
    // Switching to the comparator gives a falling edge, ignored here
    cpu.wr16(`TMR_IDX_CNT_L, 16'h0A0B);
    ACMP_CAPTURE_SEL = 1'b1;
    cycles(2);
    ACMP_OUT = 1'b1;
    cycles(3);
    cpu.rd16(`TMR_IDX_CAP_L, w);
    check("capture comparator", w, 16'h0A0B);
    // Captured value as top: the source edge must not capture
    cpu.wr16(`TMR_IDX_CAP_L, 16'h0004);
    cpu.wr16(`TMR_IDX_CNT_L, 16'h0000);
    cpu.wr(`TMR_IDX_IRQ_FLAG, 8'hFF);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h19);
    ACMP_OUT = 1'b0;
    cycles(12);
    cpu.wr(`TMR_IDX_CTRL_B, 8'h00);
    cpu.rd16(`TMR_IDX_CAP_L, w);
    check("capture off at top", w, 16'h0004);
    cpu.rd(`TMR_IDX_IRQ_FLAG, b);
    check("capture flag at top", 16'(b & 8'h20), 16'h0020);
    $display("test capture done");
    conclude();
  end
endmodule
